// [ext_config_bank.sv]
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps

// Contract
// RQ1: Power budget byte is writable but steers nothing in the block.
// RQ2: Max enhanced area = max multiplier x group x erase unit x 512 kbytes.
// RQ3: Host keeps enhanced partitions plus enhanced user area within maximum.
// RQ4: Each partition size = weighted multiplier bytes x group x erase x 512k.
// RQ5: Enhanced user area size = weighted multiplier x group x erase x 512k.
// RQ6: Background trigger byte is write only and is not kept.
// RQ7: Background enable byte is read/write and reads zero until set.
// RQ8: Reliable write setting is read/write, zero; parameter reads 0x05.
// RQ9: Boot protection byte mixes read/write and clearable bits; resets zero. Block stores every bit as plain read/write.
// RQ10: Protect group size reads 0x01, erase unit size reads 0x10. Block has no byte for either; both only feed the size formula.
// RQ11: Writes to fixed or reserved bytes change nothing; reserved reads zero.
module ext_config_bank
  import ext_config_pkg::*;
(
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // Register port
  input  wire logic [ext_config_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [ext_config_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [ext_config_pkg::DATA_W-1:0] reg_rdata,
  // Derived sizes in bytes and the enhanced over-budget flag
  output logic      [ext_config_pkg::SIZE_W-1:0] max_enhanced_bytes,
  output logic      [ext_config_pkg::SIZE_W-1:0] enhanced_user_bytes,
  output logic      [ext_config_pkg::SIZE_W-1:0] general_partition_bytes
                                                   [ext_config_pkg::GP_COUNT],
  output logic                           enhanced_over_budget,
  // Settings to the rest of the device
  output logic                           background_work_start,
  output logic      [7:0]                background_work_enable,
  output logic      [7:0]                reliable_write_setting,
  output logic      [7:0]                boot_area_protection,
  output logic      [7:0]                partition_selection
);
  import ext_config_pkg::*;

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  // Access class of every byte position; unlisted positions are reserved
  typedef enum logic [2:0]
  {
    ACC_RESERVED,
    ACC_FIXED,
    ACC_READ_WRITE,
    ACC_WRITE_ONLY,
    ACC_TRIGGER
  } access_t;

  function automatic access_t access_of(input logic [7:0] a);
    case (a) inside
      OFS_BAD_BLOCK_MODE:                  access_of = ACC_READ_WRITE;
      [OFS_ENH_START_LO:OFS_ENH_START_HI]: access_of = ACC_READ_WRITE;
      [OFS_ENH_SIZE_LO:OFS_ENH_SIZE_HI]:   access_of = ACC_READ_WRITE;
      [OFS_GP_SIZE_LO:OFS_GP_SIZE_HI]:     access_of = ACC_READ_WRITE;
      OFS_PART_DONE:                       access_of = ACC_READ_WRITE;
      OFS_PART_ATTR:                       access_of = ACC_READ_WRITE;
      [OFS_MAX_ENH_LO:OFS_MAX_ENH_HI]:     access_of = ACC_FIXED;
      OFS_PART_CAPABILITY:                 access_of = ACC_FIXED;
      OFS_PRIO_INT_CTRL:                   access_of = ACC_READ_WRITE;
      OFS_HW_RESET_FUNC:                   access_of = ACC_READ_WRITE;
      OFS_BG_ENABLE:                       access_of = ACC_READ_WRITE;
      OFS_BG_TRIGGER:                      access_of = ACC_TRIGGER; // see RQ6
      OFS_REL_WR_PARAM:                    access_of = ACC_FIXED;
      OFS_REL_WR_SETTING:                  access_of = ACC_READ_WRITE;
      OFS_REPLAY_AREA:                     access_of = ACC_FIXED;
      OFS_FIRMWARE_CONFIGURATION:                       access_of = ACC_READ_WRITE;
      OFS_USER_PROTECT:                    access_of = ACC_READ_WRITE;
      OFS_BOOT_PROTECT:                    access_of = ACC_READ_WRITE;
      OFS_ERASE_GROUP_DEFINITION:                 access_of = ACC_READ_WRITE;
      OFS_BOOT_BUS_CFG:                    access_of = ACC_READ_WRITE;
      OFS_BOOT_CFG_LOCK:                   access_of = ACC_READ_WRITE;
      OFS_PART_SELECT:                     access_of = ACC_READ_WRITE;
      OFS_ERASED_CONTENT:                  access_of = ACC_FIXED;
      OFS_BUS_WIDTH_SEL:                   access_of = ACC_WRITE_ONLY;
      OFS_FAST_TIMING:                     access_of = ACC_READ_WRITE;
      OFS_POWER_BUDGET:                    access_of = ACC_READ_WRITE;
      OFS_CMD_GROUP_REV:                   access_of = ACC_FIXED;
      OFS_CMD_GROUP_SEL:                   access_of = ACC_READ_WRITE;
      OFS_EXT_TABLE_REV:                   access_of = ACC_FIXED;
      OFS_BASE_TABLE_VER:                  access_of = ACC_FIXED;
      OFS_SPEED_TYPES:                     access_of = ACC_FIXED;
      OFS_INT_EXIT_TIME:                   access_of = ACC_FIXED;
      OFS_PART_SWITCH_TIME:                access_of = ACC_FIXED;
      OFS_CLASS_FAST_LV:                   access_of = ACC_FIXED;
      OFS_CLASS_SLOW_LV:                   access_of = ACC_FIXED;
      OFS_CLASS_FAST_HV:                   access_of = ACC_FIXED;
      OFS_CLASS_SLOW_HV:                   access_of = ACC_FIXED;
      OFS_MIN_RD_NARROW:                   access_of = ACC_FIXED;
      OFS_MIN_WR_NARROW:                   access_of = ACC_FIXED;
      OFS_MIN_RD_MID:                      access_of = ACC_FIXED;
      OFS_MIN_WR_MID:                      access_of = ACC_FIXED;
      default:                             access_of = ACC_RESERVED; // see RQ11
    endcase
  endfunction

  // Bytes that keep what the host writes
  function automatic logic is_writable(input logic [7:0] a);
    is_writable = (access_of(a) == ACC_READ_WRITE) || (access_of(a) == ACC_WRITE_ONLY);
  endfunction

  // Write-only bytes read back as zero
  function automatic logic is_write_only(input logic [7:0] a);
    is_write_only = (access_of(a) == ACC_WRITE_ONLY) || (access_of(a) == ACC_TRIGGER);
  endfunction

  function automatic logic [7:0] fixed_value(input logic [7:0] a);
    case (a)
      OFS_MAX_ENH_LO:       fixed_value = MAX_ENH_VALUE[7:0];
      OFS_MAX_ENH_MID:      fixed_value = MAX_ENH_VALUE[15:8];
      OFS_MAX_ENH_HI:       fixed_value = MAX_ENH_VALUE[23:16];
      OFS_PART_CAPABILITY:  fixed_value = PART_CAPABILITY_VAL;
      OFS_REL_WR_PARAM:     fixed_value = REL_WR_PARAM_VAL; // see RQ8
      OFS_REPLAY_AREA:      fixed_value = REPLAY_AREA_VAL;
      OFS_ERASED_CONTENT:   fixed_value = ERASED_CONTENT_VAL;
      OFS_CMD_GROUP_REV:    fixed_value = CMD_GROUP_REV_VAL;
      OFS_EXT_TABLE_REV:    fixed_value = EXT_TABLE_REV_VAL;
      OFS_BASE_TABLE_VER:   fixed_value = BASE_TABLE_VER_VAL;
      OFS_SPEED_TYPES:      fixed_value = SPEED_TYPES_VAL;
      OFS_INT_EXIT_TIME:    fixed_value = INT_EXIT_TIME_VAL;
      OFS_PART_SWITCH_TIME: fixed_value = PART_SWITCH_TIME_VAL;
      OFS_CLASS_FAST_LV:    fixed_value = CLASS_LV_VAL;
      OFS_CLASS_SLOW_LV:    fixed_value = CLASS_LV_VAL;
      OFS_CLASS_FAST_HV:    fixed_value = CLASS_HV_VAL;
      OFS_CLASS_SLOW_HV:    fixed_value = CLASS_HV_VAL;
      OFS_MIN_RD_NARROW:    fixed_value = MIN_RD_NARROW_VAL;
      OFS_MIN_WR_NARROW:    fixed_value = MIN_WR_VAL;
      OFS_MIN_RD_MID:       fixed_value = MIN_RD_MID_VAL;
      OFS_MIN_WR_MID:       fixed_value = MIN_WR_VAL;
      default:              fixed_value = 8'h00; // see RQ11
    endcase
  endfunction

  // Multiplier x group x erase unit, in 512 kbyte units
  function automatic logic [SIZE_W-1:0] area_bytes(input logic [23:0] mult);
    logic [SIZE_W-1:0] units;
    units = SIZE_W'(mult) * SIZE_W'(PROTECT_GROUP_VAL) * SIZE_W'(ERASE_UNIT_VAL); // see RQ10
    area_bytes = units << UNIT_SHIFT;
  endfunction

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] byte_reg [0:255];
  logic       wr_hit;
  logic       trigger_hit;

  // see RQ11
  assign wr_hit = reg_write && (reg_addr <= LAST_BYTE) && is_writable(reg_addr);
  assign trigger_hit = reg_write && (access_of(reg_addr) == ACC_TRIGGER);

  // Power budget byte is only stored, see RQ1; boot protection resets, see RQ9
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 256; i++)
        byte_reg[i] <= WRITABLE_RESET;
    end
    else if (wr_hit && reg_addr != OFS_BG_TRIGGER)
    begin
      byte_reg[reg_addr] <= reg_wdata; // see RQ7
    end
  end

  // Trigger byte becomes a pulse, never held, see RQ6
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      background_work_start <= 1'b0;
    else
      background_work_start <= trigger_hit && (reg_wdata != 8'h00);
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_read)
    begin
      if (reg_addr > LAST_BYTE || is_write_only(reg_addr))
        reg_rdata <= 8'h00; // see RQ6
      else if (is_writable(reg_addr))
        reg_rdata <= byte_reg[reg_addr];
      else
        reg_rdata <= fixed_value(reg_addr); // see RQ11
    end
    else
      reg_rdata <= 8'h00;
  end

  // ------------------------------------------------------------
  // Size computation
  // ------------------------------------------------------------
  logic [23:0]       enh_mult;
  logic [23:0]       gp_mult [GP_COUNT];
  logic [SIZE_W-1:0] enh_sum;

  assign enh_mult = {byte_reg[OFS_ENH_SIZE_LO + 8'h02], byte_reg[OFS_ENH_SIZE_LO + 8'h01],
                     byte_reg[OFS_ENH_SIZE_LO]};

  for (genvar g = 0; g < GP_COUNT; g++)
  begin : gen_gp
    localparam logic [7:0] BASE = OFS_GP_SIZE_LO + 8'(3 * g);
    assign gp_mult[g] = {byte_reg[BASE + 8'h02], byte_reg[BASE + 8'h01], byte_reg[BASE]};

    always_ff @(posedge core_clk or negedge rstn)
    begin
      if (!rstn)
        general_partition_bytes[g] <= '0;
      else
        general_partition_bytes[g] <= area_bytes(gp_mult[g]); // see RQ4
    end
  end

  // Enhanced total counts user area and partitions flagged enhanced
  always_comb
  begin
    enh_sum = '0;
    if (byte_reg[OFS_PART_ATTR][ATTR_ENH_USER])
      enh_sum = area_bytes(enh_mult);
    for (int g = 0; g < GP_COUNT; g++)
      if (byte_reg[OFS_PART_ATTR][g + 1])
        enh_sum = enh_sum + area_bytes(gp_mult[g]);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      max_enhanced_bytes   <= '0;
      enhanced_user_bytes  <= '0;
      enhanced_over_budget <= 1'b0;
    end
    else
    begin
      max_enhanced_bytes   <= area_bytes(MAX_ENH_VALUE);       // see RQ2
      enhanced_user_bytes  <= area_bytes(enh_mult);            // see RQ5
      enhanced_over_budget <= enh_sum > area_bytes(MAX_ENH_VALUE); // see RQ3
    end
  end

  // ------------------------------------------------------------
  // Settings out
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      background_work_enable <= 8'h00;
      reliable_write_setting <= 8'h00;
      boot_area_protection   <= 8'h00;
      partition_selection    <= 8'h00;
    end
    else
    begin
      background_work_enable <= byte_reg[OFS_BG_ENABLE];
      reliable_write_setting <= byte_reg[OFS_REL_WR_SETTING]; // see RQ8
      boot_area_protection   <= byte_reg[OFS_BOOT_PROTECT];   // see RQ9
      partition_selection    <= byte_reg[OFS_PART_SELECT];
    end
  end

endmodule // ext_config_bank

// [ext_config_pkg.sv]
package ext_config_pkg;

  // ------------------------------------------------------------
  // Bus geometry
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned SIZE_W    = 64;
  localparam logic [7:0]  LAST_BYTE = 8'hd0;

  // ------------------------------------------------------------
  // Byte positions of host writable fields
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_BAD_BLOCK_MODE   = 8'h86;
  localparam logic [7:0] OFS_ENH_START_LO     = 8'h88;
  localparam logic [7:0] OFS_ENH_START_HI     = 8'h8b;
  localparam logic [7:0] OFS_ENH_SIZE_LO      = 8'h8c;
  localparam logic [7:0] OFS_ENH_SIZE_HI      = 8'h8e;
  localparam logic [7:0] OFS_GP_SIZE_LO       = 8'h8f;
  localparam logic [7:0] OFS_GP_SIZE_HI       = 8'h9a;
  localparam logic [7:0] OFS_PART_DONE        = 8'h9b;
  localparam logic [7:0] OFS_PART_ATTR        = 8'h9c;
  localparam logic [7:0] OFS_PRIO_INT_CTRL    = 8'ha1;
  localparam logic [7:0] OFS_HW_RESET_FUNC    = 8'ha2;
  localparam logic [7:0] OFS_BG_ENABLE        = 8'ha3;
  localparam logic [7:0] OFS_BG_TRIGGER       = 8'ha4;
  localparam logic [7:0] OFS_REL_WR_SETTING   = 8'ha7;
  localparam logic [7:0] OFS_FIRMWARE_CONFIGURATION        = 8'ha9;
  localparam logic [7:0] OFS_USER_PROTECT     = 8'hab;
  localparam logic [7:0] OFS_BOOT_PROTECT     = 8'had;
  localparam logic [7:0] OFS_ERASE_GROUP_DEFINITION  = 8'haf;
  localparam logic [7:0] OFS_BOOT_BUS_CFG     = 8'hb1;
  localparam logic [7:0] OFS_BOOT_CFG_LOCK    = 8'hb2;
  localparam logic [7:0] OFS_PART_SELECT      = 8'hb3;
  localparam logic [7:0] OFS_BUS_WIDTH_SEL    = 8'hb7;
  localparam logic [7:0] OFS_FAST_TIMING      = 8'hb9;
  localparam logic [7:0] OFS_POWER_BUDGET     = 8'hbb;
  localparam logic [7:0] OFS_CMD_GROUP_SEL    = 8'hbf;

  // ------------------------------------------------------------
  // Byte positions of fixed fields
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_MAX_ENH_LO       = 8'h9d;
  localparam logic [7:0] OFS_MAX_ENH_MID      = 8'h9e;
  localparam logic [7:0] OFS_MAX_ENH_HI       = 8'h9f;
  localparam logic [7:0] OFS_PART_CAPABILITY  = 8'ha0;
  localparam logic [7:0] OFS_REL_WR_PARAM     = 8'ha6;
  localparam logic [7:0] OFS_REPLAY_AREA      = 8'ha8;
  localparam logic [7:0] OFS_ERASED_CONTENT   = 8'hb5;
  localparam logic [7:0] OFS_CMD_GROUP_REV    = 8'hbd;
  localparam logic [7:0] OFS_EXT_TABLE_REV    = 8'hc0;
  localparam logic [7:0] OFS_BASE_TABLE_VER   = 8'hc2;
  localparam logic [7:0] OFS_SPEED_TYPES      = 8'hc4;
  localparam logic [7:0] OFS_INT_EXIT_TIME    = 8'hc6;
  localparam logic [7:0] OFS_PART_SWITCH_TIME = 8'hc7;
  localparam logic [7:0] OFS_CLASS_FAST_LV    = 8'hc8;
  localparam logic [7:0] OFS_CLASS_SLOW_LV    = 8'hc9;
  localparam logic [7:0] OFS_CLASS_FAST_HV    = 8'hca;
  localparam logic [7:0] OFS_CLASS_SLOW_HV    = 8'hcb;
  localparam logic [7:0] OFS_MIN_RD_NARROW    = 8'hcd;
  localparam logic [7:0] OFS_MIN_WR_NARROW    = 8'hce;
  localparam logic [7:0] OFS_MIN_RD_MID       = 8'hcf;
  localparam logic [7:0] OFS_MIN_WR_MID       = 8'hd0;

  // ------------------------------------------------------------
  // Fixed values
  // ------------------------------------------------------------
  localparam logic [23:0] MAX_ENH_VALUE        = 24'h0003b6;
  localparam logic [7:0]  PART_CAPABILITY_VAL  = 8'h03;
  localparam logic [7:0]  REL_WR_PARAM_VAL     = 8'h05;
  localparam logic [7:0]  REPLAY_AREA_VAL      = 8'h02;
  localparam logic [7:0]  ERASED_CONTENT_VAL   = 8'h01;
  localparam logic [7:0]  CMD_GROUP_REV_VAL    = 8'h00;
  localparam logic [7:0]  EXT_TABLE_REV_VAL    = 8'h05;
  localparam logic [7:0]  BASE_TABLE_VER_VAL   = 8'h02;
  localparam logic [7:0]  SPEED_TYPES_VAL      = 8'h07;
  localparam logic [7:0]  INT_EXIT_TIME_VAL    = 8'h05;
  localparam logic [7:0]  PART_SWITCH_TIME_VAL = 8'h01;
  localparam logic [7:0]  CLASS_LV_VAL         = 8'h44;
  localparam logic [7:0]  CLASS_HV_VAL         = 8'h00;
  localparam logic [7:0]  MIN_RD_NARROW_VAL    = 8'h1e;
  localparam logic [7:0]  MIN_WR_VAL           = 8'h00;
  localparam logic [7:0]  MIN_RD_MID_VAL       = 8'h3c;
  localparam logic [7:0]  PROTECT_GROUP_VAL    = 8'h01;
  localparam logic [7:0]  ERASE_UNIT_VAL       = 8'h10;
  localparam logic [7:0]  WRITABLE_RESET       = 8'h00;

  // ------------------------------------------------------------
  // Size formula: multiplier units of 512 kbytes
  // ------------------------------------------------------------
  localparam int unsigned UNIT_SHIFT  = 19;
  localparam int unsigned GP_COUNT    = 4;
  localparam int unsigned ATTR_ENH_USER = 0;

endpackage

// [ext_config_properties.sv]
`timescale 1ns/100ps
module ext_config_properties
  import ext_config_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic [63:0] max_enhanced_bytes,
  input wire logic        background_work_start,
  input wire logic [7:0]  background_work_enable,
  input wire logic [7:0]  reliable_write_setting,
  input wire logic [7:0]  boot_area_protection
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  a_trigger_reads_zero: assert property (reg_read && reg_addr == 8'ha4 |=> reg_rdata == 8'h00)
    else $error("trigger byte read back nonzero");
  a_trigger_pulse: assert property (reg_write && reg_addr == 8'ha4 && reg_wdata != 8'h00
    |=> background_work_start ##1 !background_work_start)
    else $error("trigger pulse missing or long");
  a_trigger_cause: assert property (background_work_start
    |-> $past(reg_write) && $past(reg_addr) == 8'ha4)
    else $error("trigger pulse without a trigger write");
  a_param_fixed: assert property (reg_read && reg_addr == 8'ha6 |=> reg_rdata == 8'h05)
    else $error("reliable write parameter wrong");
  a_max_size: assert property ($past(rstn) |-> max_enhanced_bytes == (64'h3b6 << 23))
    else $error("max enhanced size wrong");
  a_enable_copy: assert property (reg_write && reg_addr == 8'ha3
    |-> ##2 background_work_enable == $past(reg_wdata, 2))
    else $error("enable copy wrong");
  a_setting_copy: assert property (reg_write && reg_addr == 8'ha7
    |-> ##2 reliable_write_setting == $past(reg_wdata, 2))
    else $error("setting copy wrong");
  a_boot_cause: assert property ($changed(boot_area_protection)
    |-> $past(reg_write, 2) && $past(reg_addr, 2) == 8'had)
    else $error("boot protection changed without a write");
  a_power_inert: assert property (reg_write && reg_addr == 8'hbb
    |-> ##2 $stable(background_work_enable) && $stable(reliable_write_setting))
    else $error("power budget write moved a setting");
  a_reserved_zero: assert property (reg_read && reg_addr > 8'hd0 |=> reg_rdata == 8'h00)
    else $error("unmapped byte read nonzero");
endmodule // ext_config_properties

bind ext_config_bank ext_config_properties checker_i (.core_clk, .rstn, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .max_enhanced_bytes, .background_work_start,
  .background_work_enable, .reliable_write_setting, .boot_area_protection);

// [host_model.sv]
`timescale 1ns/100ps
module host_model
(
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end
  // Released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // host_model

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
  import ext_config_pkg::*;
  logic        core_clk, rstn, reg_write, reg_read, enhanced_over_budget, background_work_start;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, background_work_enable, reliable_write_setting;
  logic [7:0]  boot_area_protection, partition_selection, d, r;
  logic [63:0] max_enhanced_bytes, enhanced_user_bytes, general_partition_bytes [4];
  logic [23:0] m;
  int          mismatches, comparisons, cycles, seed;
  localparam logic [15:0] FIXED [21] = '{16'h9db6, 16'h9e03, 16'h9f00, 16'ha003, 16'ha605,
    16'ha802, 16'hb501, 16'hbd00, 16'hc005, 16'hc202, 16'hc407, 16'hc605, 16'hc701, 16'hc844,
    16'hc944, 16'hca00, 16'hcb00, 16'hcd1e, 16'hce00, 16'hcf3c, 16'hd000};
  localparam logic [7:0] RW [8] = '{8'h86, 8'ha1, 8'ha2, 8'ha3, 8'ha7, 8'had, 8'hb3, 8'hbb};
  localparam logic [7:0] HOLE [8] = '{8'h00, 8'h85, 8'h87, 8'ha5, 8'haa, 8'hbc, 8'hd1, 8'hff};

  ext_config_bank dut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .max_enhanced_bytes, .enhanced_user_bytes, .general_partition_bytes,
    .enhanced_over_budget, .background_work_start, .background_work_enable,
    .reliable_write_setting, .boot_area_protection, .partition_selection);
  host_model host (.core_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read);

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  function automatic logic [63:0] size_of(input logic [23:0] mult);
    return (64'(mult) * 64'h01 * 64'h10) << 19;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  initial
  begin
    seed = 32'hc82438b7;
    rstn = 1'b0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (FIXED[i])
    begin
      host.rd(FIXED[i][15:8], r);
      chk(r, FIXED[i][7:0]);
      host.wr(FIXED[i][15:8], 8'($random(seed)));
      host.rd(FIXED[i][15:8], r);
      chk(r, FIXED[i][7:0]);
    end
    foreach (RW[i])
    begin
      host.rd(RW[i], r);
      chk(r, 8'h00);
      d = 8'($random(seed));
      host.wr(RW[i], d);
      host.rd(RW[i], r);
      chk(r, d);
      case (RW[i])
        8'ha3: chk(background_work_enable, d);
        8'ha7: chk(reliable_write_setting, d);
        8'had: chk(boot_area_protection, d);
        8'hb3: chk(partition_selection, d);
        default: chk(background_work_start, 1'b0);
      endcase
    end
    foreach (HOLE[i])
    begin
      host.wr(HOLE[i], 8'($random(seed)));
      host.rd(HOLE[i], r);
      chk(r, 8'h00);
    end
    host.wr(8'ha4, 8'h5a);
    #1 chk(background_work_start, 1'b1);
    host.rd(8'ha4, r);
    chk(r, 8'h00);
    for (int g = 0; g < 5; g++)
    begin
      m = (g == 1) ? 24'hffffff : 24'($random(seed));
      for (int b = 0; b < 3; b++)
        host.wr(8'h8c + 8'(3 * g + b), m[8 * b +: 8]);
      repeat (2) @(posedge core_clk);
      if (g == 0)
        chk(enhanced_user_bytes, size_of(m));
      else
        chk(general_partition_bytes[g - 1], size_of(m));
    end
    chk(enhanced_over_budget, 1'b0);
    chk(max_enhanced_bytes, size_of(24'h0003b6));
    m = 24'h0003b6;
    for (int b = 0; b < 3; b++)
      host.wr(8'h8c + 8'(b), m[8 * b +: 8]);
    host.wr(8'h9c, 8'h01);
    repeat (2) @(posedge core_clk);
    chk(enhanced_over_budget, 1'b0);
    host.wr(8'h9c, 8'h03);
    repeat (2) @(posedge core_clk);
    chk(enhanced_over_budget, 1'b1);
    rstn <= 1'b0;
    @(posedge core_clk);
    rstn <= 1'b1;
    host.rd(8'had, r);
    chk(r, 8'h00);
    chk(boot_area_protection, 8'h00);
    report_and_stop();
  end
endmodule // testbench
